// ---- adc_config_word_lower_fields.sv ----
// serial capture and storage of the converter configuration word
// assumes cnv, sck and sdi arrive as pins; eoc is a one-cycle pulse on clock
`include "adc_cfg_params.svh"
module adc_config_word_lower_fields
    import adc_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // serial pins from the host
    input  wire logic        cnv,
    input  wire logic        sck,
    input  wire logic        sdi,
    // converter core
    input  wire logic        eoc,
    // stored word and decoded settings
    output logic [13:0]      cfg_word,
    output logic [2:0]       input_channel_index,
    output logic [7:0]       channel_select,
    output logic             filter_bandwidth_select,
    output logic             quarter_bandwidth,
    output logic [2:0]       rate_divider,
    output logic             int_ref_en,
    output logic             ref_drive_out,
    output logic             ref_buf_en,
    output logic             ext_ref_sel,
    output logic             temp_sensor_en,
    output logic [1:0]       channel_scan_mode,
    output logic             config_readback_disable,
    output logic             readback_append,
    // sequencer and status
    output logic             scan_active,
    output logic [2:0]       conv_channel,
    output logic             conv_temp_slot,
    output logic             word_refused
);
    typedef struct packed {
        logic         cnv_m;
        logic         cnv_s;
        logic         sck_m;
        logic         sck_s;
        logic         sdi_m;
        logic         sdi_s;
        logic         cnv_q;
        logic         sck_q;
        shift_state_t fsm;
        logic [3:0]   bit_cnt;
        logic [12:0]  shift;
        cfg_word_t    cfg;
        logic [2:0]   seq_idx;
        logic         seq_temp;
        logic [2:0]   conv_chan;
        logic         conv_temp;
        logic         refused;
    } top_state_t;

    top_state_t st_ff;
    top_state_t nxt_st;

    cfg_fields_if fields ();

    logic      sck_rise;
    logic      cnv_rise;
    logic      cnv_fall;
    logic      word_done;
    cfg_word_t new_word;

    // ------------------------------------------------------------------
    // edge detection on the synchronised pins
    // ------------------------------------------------------------------
    assign sck_rise  = st_ff.sck_s & ~st_ff.sck_q;
    assign cnv_rise  = st_ff.cnv_s & ~st_ff.cnv_q;
    assign cnv_fall  = ~st_ff.cnv_s & st_ff.cnv_q;
    assign new_word  = cfg_word_t'({st_ff.shift, st_ff.sdi_s});
    // a conversion start outranks a word that lands in the same cycle
    assign word_done = (st_ff.fsm == ST_SHIFT) && sck_rise && !cnv_rise
                     && !eoc && (st_ff.bit_cnt == `CFG_LAST_BIT);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.cnv_m   = cnv;
        nxt_st.cnv_s   = st_ff.cnv_m;
        nxt_st.sck_m   = sck;
        nxt_st.sck_s   = st_ff.sck_m;
        nxt_st.sdi_m   = sdi;
        nxt_st.sdi_s   = st_ff.sdi_m;
        nxt_st.cnv_q   = st_ff.cnv_s;
        nxt_st.sck_q   = st_ff.sck_s;
        nxt_st.refused = 1'b0;

        // shift path: sdi is ignored from a conversion start onward
        if (cnv_rise) begin
            nxt_st.fsm = ST_IDLE;
        end else if (eoc) begin
            // a partial word dies at end of conversion
            nxt_st.bit_cnt = `CFG_CNT_ZERO;
            nxt_st.fsm     = st_ff.cnv_s ? ST_IDLE : ST_SHIFT;
        end else begin
            case (st_ff.fsm)
                ST_IDLE: begin
                    if (cnv_fall) begin
                        nxt_st.fsm     = ST_SHIFT;
                        nxt_st.bit_cnt = `CFG_CNT_ZERO;
                    end
                end
                ST_SHIFT: begin
                    if (sck_rise) begin
                        nxt_st.shift = {st_ff.shift[11:0], st_ff.sdi_s};
                        if (st_ff.bit_cnt == `CFG_LAST_BIT) begin
                            nxt_st.fsm = ST_HOLD;
                        end else begin
                            nxt_st.bit_cnt = st_ff.bit_cnt + `CFG_CNT_STEP;
                        end
                    end
                end
                ST_HOLD: begin
                    nxt_st.fsm = ST_HOLD; // later edges of the frame are not ours
                end
                default: begin
                    nxt_st.fsm = ST_IDLE;
                end
            endcase
        end

        // commit of a complete word
        if (word_done && new_word.update) begin
            if (ref_reserved(new_word.ref_code)) begin
                nxt_st.refused = 1'b1;
            end else if (st_ff.cfg.channel_scan_mode[1]
                         && new_word.channel_scan_mode == `SCAN_UPDATE) begin
                // running scan keeps its mode and position
                nxt_st.cfg                   = new_word;
                nxt_st.cfg.channel_scan_mode = st_ff.cfg.channel_scan_mode;
            end else begin
                nxt_st.cfg      = new_word;
                nxt_st.seq_idx  = `CHAN_ZERO;
                nxt_st.seq_temp = 1'b0;
            end
        end

        // sequencer steps once per conversion start
        if (cnv_rise) begin
            if (st_ff.cfg.channel_scan_mode[1]) begin
                nxt_st.conv_chan = st_ff.seq_idx;
                nxt_st.conv_temp = st_ff.seq_temp;
                if (st_ff.seq_temp) begin
                    nxt_st.seq_idx  = `CHAN_ZERO;
                    nxt_st.seq_temp = 1'b0;
                end else if (st_ff.seq_idx == st_ff.cfg.input_channel_index) begin
                    nxt_st.seq_idx  = `CHAN_ZERO;
                    nxt_st.seq_temp = (st_ff.cfg.channel_scan_mode == `SCAN_TEMP);
                end else begin
                    nxt_st.seq_idx = st_ff.seq_idx + `CHAN_STEP;
                end
            end else begin
                nxt_st.conv_chan = st_ff.cfg.input_channel_index;
                nxt_st.conv_temp = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff     <= '0;
            st_ff.fsm <= ST_IDLE;
            st_ff.cfg <= cfg_word_t'(`CFG_RESET_WORD);
            // conversion pin idles high: start its flops high so release shows no edge
            st_ff.cnv_m <= 1'b1;
            st_ff.cnv_s <= 1'b1;
            st_ff.cnv_q <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // field decode and outputs
    // ------------------------------------------------------------------
    assign fields.word = st_ff.cfg;

    cfg_field_decode u_decode (
        .clock  (clock),
        .arst_n (arst_n),
        .f      (fields.decoder)
    );

    assign cfg_word                = st_ff.cfg;
    assign input_channel_index     = st_ff.cfg.input_channel_index;
    assign filter_bandwidth_select = st_ff.cfg.filter_bandwidth_select;
    assign channel_scan_mode       = st_ff.cfg.channel_scan_mode;
    assign config_readback_disable = st_ff.cfg.config_readback_disable;
    assign channel_select          = fields.chan_sel;
    assign quarter_bandwidth       = fields.quarter_bw;
    assign rate_divider            = fields.rate_div;
    assign int_ref_en              = fields.int_ref_en;
    assign ref_drive_out           = fields.ref_out_en;
    assign ref_buf_en              = fields.buf_en;
    assign ext_ref_sel             = fields.ext_ref;
    assign temp_sensor_en          = fields.temp_en;
    assign readback_append         = fields.readback_on;
    assign scan_active             = st_ff.cfg.channel_scan_mode[1];
    assign conv_channel            = st_ff.conv_chan;
    assign conv_temp_slot          = st_ff.conv_temp;
    assign word_refused            = st_ff.refused;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking tck @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_keep_on_zero: assert property (word_done && !new_word.update
        |=> st_ff.cfg == $past(st_ff.cfg))
        else $error("word with clear update flag changed settings");
    a_commit_word: assert property (word_done && new_word.update
        && !ref_reserved(new_word.ref_code) && !st_ff.cfg.channel_scan_mode[1]
        |=> st_ff.cfg == $past(new_word))
        else $error("complete word not stored");
    a_eoc_discard: assert property (eoc && !cnv_rise && st_ff.fsm == ST_SHIFT
        |=> st_ff.bit_cnt == `CFG_CNT_ZERO ##1 st_ff.cfg == $past(st_ff.cfg, 2))
        else $error("partial word survived end of conversion");
    a_ref_reserved: assert property (!ref_reserved(st_ff.cfg.ref_code)
        and (word_done && ref_reserved(new_word.ref_code) && new_word.update |=> word_refused))
        else $error("reserved reference code stored or not flagged");
    a_scan_keep: assert property (word_done && new_word.update && st_ff.cfg.channel_scan_mode[1]
        && !ref_reserved(new_word.ref_code) && new_word.channel_scan_mode == `SCAN_UPDATE
        |=> $stable(st_ff.cfg.channel_scan_mode) && $stable(st_ff.seq_idx))
        else $error("update during sequence disturbed the scan");
    a_scan_temp: assert property (cnv_rise && st_ff.cfg.channel_scan_mode == `SCAN_TEMP
        && !st_ff.seq_temp && st_ff.seq_idx == st_ff.cfg.input_channel_index
        |=> st_ff.seq_temp && st_ff.seq_idx == `CHAN_ZERO)
        else $error("temperature slot missing after last channel");
    a_scan_plain: assert property (cnv_rise && st_ff.cfg.channel_scan_mode == `SCAN_PLAIN
        |=> !st_ff.conv_temp && !st_ff.seq_temp)
        else $error("temperature slot in plain scan");

    c_word_stored: cover property (word_done && new_word.update ##1 !word_refused);
    c_word_refused: cover property (word_refused);
    c_temp_slot: cover property (cnv_rise && st_ff.seq_temp ##1 conv_temp_slot);
    c_partial_drop: cover property (eoc && st_ff.fsm == ST_SHIFT
        && st_ff.bit_cnt != `CFG_CNT_ZERO);
endmodule : adc_config_word_lower_fields

// ---- adc_cfg_params.svh ----
// constants of the converter configuration word: widths, codes, reset value
// assumes inclusion by bare name from the package and the design modules
`ifndef ADC_CFG_PARAMS_SVH
`define ADC_CFG_PARAMS_SVH

// ----------------------------------------------------------------------
// word shape and serial count
// ----------------------------------------------------------------------
`define CFG_LAST_BIT      4'hd
`define CFG_CNT_ZERO      4'h0
`define CFG_CNT_STEP      4'h1
`define CFG_RESET_WORD    14'h3ff9

// ----------------------------------------------------------------------
// reference field codes
// ----------------------------------------------------------------------
`define REF_RSVD_A        3'h0
`define REF_INT_TEMP      3'h1
`define REF_EXT_TEMP      3'h2
`define REF_EXT_BUF_TEMP  3'h3
`define REF_RSVD_B        3'h4
`define REF_RSVD_C        3'h5
`define REF_EXT_ONLY      3'h6
`define REF_EXT_BUF       3'h7

// ----------------------------------------------------------------------
// scan mode codes, channels, throughput divisors
// ----------------------------------------------------------------------
`define SCAN_OFF          2'h0
`define SCAN_UPDATE       2'h1
`define SCAN_TEMP         2'h2
`define SCAN_PLAIN        2'h3
`define CHAN_ZERO         3'h0
`define CHAN_STEP         3'h1
`define RATE_FULL_DIV     3'h1
`define RATE_QUARTER_DIV  3'h4
`define CHAN_ONE_HOT      8'h01

`endif

// ---- adc_cfg_pkg.sv ----
// types shared by the configuration word logic and its field decoder
// assumes adc_cfg_params.svh is on the include path
package adc_cfg_pkg;
    `include "adc_cfg_params.svh"

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       update;
        logic [2:0] input_config;
        logic [2:0] input_channel_index;
        logic       filter_bandwidth_select;
        logic [2:0] ref_code;
        logic [1:0] channel_scan_mode;
        logic       config_readback_disable;
    } cfg_word_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_HOLD  = 3'b100
    } shift_state_t;

    // reserved reference codes must never be stored
    function automatic logic ref_reserved(input logic [2:0] code);
        ref_reserved = (code == `REF_RSVD_A) || (code == `REF_RSVD_B)
                     || (code == `REF_RSVD_C);
    endfunction : ref_reserved
endpackage : adc_cfg_pkg

// ---- cfg_fields_if.sv ----
// carries the stored word to the field decoder and decoded controls back
// assumes one clock domain shared by both ends
interface cfg_fields_if;
    import adc_cfg_pkg::*;
    cfg_word_t   word;
    logic [7:0]  chan_sel;
    logic [2:0]  rate_div;
    logic        quarter_bw;
    logic        int_ref_en;
    logic        ref_out_en;
    logic        buf_en;
    logic        ext_ref;
    logic        temp_en;
    logic        readback_on;

    modport producer (output word, input chan_sel, rate_div, quarter_bw, int_ref_en,
                      ref_out_en, buf_en, ext_ref, temp_en, readback_on);
    modport decoder  (input word, output chan_sel, rate_div, quarter_bw, int_ref_en,
                      ref_out_en, buf_en, ext_ref, temp_en, readback_on);
endinterface : cfg_fields_if

// ---- cfg_field_decode.sv ----
// registered decode of the stored word into analog and readback controls
// assumes the word comes from flip-flops on the same clock
`include "adc_cfg_params.svh"
module cfg_field_decode
    import adc_cfg_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    // word in, controls out
    cfg_fields_if.decoder   f
);
    typedef struct packed {
        logic [7:0] chan_sel;
        logic [2:0] rate_div;
        logic       quarter_bw;
        logic       int_ref_en;
        logic       ref_out_en;
        logic       buf_en;
        logic       ext_ref;
        logic       temp_en;
        logic       readback_on;
        logic       live;
    } dec_state_t;

    dec_state_t dec_ff;
    dec_state_t nxt_dec;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    always_comb begin
        nxt_dec            = '0;
        nxt_dec.live       = 1'b1;
        nxt_dec.chan_sel   = `CHAN_ONE_HOT << f.word.input_channel_index;
        nxt_dec.quarter_bw = ~f.word.filter_bandwidth_select;
        nxt_dec.rate_div   = f.word.filter_bandwidth_select ? `RATE_FULL_DIV
                                                            : `RATE_QUARTER_DIV;
        nxt_dec.readback_on = ~f.word.config_readback_disable;
        // reserved codes never reach here, so they fall to all-off
        case (f.word.ref_code)
            `REF_INT_TEMP: begin
                nxt_dec.int_ref_en = 1'b1;
                nxt_dec.ref_out_en = 1'b1;
                nxt_dec.buf_en     = 1'b1;
                nxt_dec.temp_en    = 1'b1;
            end
            `REF_EXT_TEMP: begin
                nxt_dec.ext_ref = 1'b1;
                nxt_dec.temp_en = 1'b1;
            end
            `REF_EXT_BUF_TEMP: begin
                nxt_dec.ext_ref = 1'b1;
                nxt_dec.buf_en  = 1'b1;
                nxt_dec.temp_en = 1'b1;
            end
            `REF_EXT_ONLY: begin
                nxt_dec.ext_ref = 1'b1;
            end
            `REF_EXT_BUF: begin
                nxt_dec.ext_ref = 1'b1;
                nxt_dec.buf_en  = 1'b1;
            end
            default: begin
                nxt_dec.ext_ref = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dec_ff <= '0;
        end else begin
            dec_ff <= nxt_dec;
        end
    end

    assign f.chan_sel   = dec_ff.chan_sel;
    assign f.rate_div   = dec_ff.rate_div;
    assign f.quarter_bw = dec_ff.quarter_bw;
    assign f.int_ref_en = dec_ff.int_ref_en;
    assign f.ref_out_en = dec_ff.ref_out_en;
    assign f.buf_en     = dec_ff.buf_en;
    assign f.ext_ref    = dec_ff.ext_ref;
    assign f.temp_en    = dec_ff.temp_en;
    assign f.readback_on = dec_ff.readback_on;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking dck @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_quarter_rate: assert property (dec_ff.live |-> (f.quarter_bw == !$past(f.word.filter_bandwidth_select))
        && (f.rate_div == (f.quarter_bw ? `RATE_QUARTER_DIV : `RATE_FULL_DIV)))
        else $error("bandwidth select and throughput divisor disagree");
    a_ref_internal: assert property (dec_ff.live && $past(f.word.ref_code) == `REF_INT_TEMP
        |-> f.int_ref_en && f.ref_out_en && f.temp_en && !f.ext_ref)
        else $error("internal reference code not decoded");
    a_ref_ext_temp: assert property (dec_ff.live && $past(f.word.ref_code) == `REF_EXT_TEMP
        |-> f.ext_ref && f.temp_en && !f.buf_en && !f.int_ref_en)
        else $error("external reference with sensor not decoded");
    a_ref_ext_both: assert property (dec_ff.live && $past(f.word.ref_code) == `REF_EXT_BUF_TEMP
        |-> f.ext_ref && f.temp_en && f.buf_en && !f.int_ref_en)
        else $error("external buffered reference with sensor not decoded");
    a_ref_ext_bare: assert property (dec_ff.live && $past(f.word.ref_code) == `REF_EXT_ONLY
        |-> f.ext_ref && !f.temp_en && !f.buf_en && !f.int_ref_en)
        else $error("bare external reference not decoded");
    a_ref_ext_buf: assert property (dec_ff.live && $past(f.word.ref_code) == `REF_EXT_BUF
        |-> f.ext_ref && f.buf_en && !f.temp_en && !f.int_ref_en)
        else $error("external buffered reference not decoded");
    a_readback_append: assert property (dec_ff.live
        |-> f.readback_on == !$past(f.word.config_readback_disable))
        else $error("readback append does not follow the disable bit");
    a_channel_onehot: assert property (dec_ff.live
        |-> $onehot(f.chan_sel) && f.chan_sel[$past(f.word.input_channel_index)])
        else $error("channel select does not match channel index");
endmodule : cfg_field_decode

// ---- cfg_host.sv ----
// host side of the serial link: cnv, sck, sdi and the end-of-conversion pulse
// assumes pins move at the falling clock edge; each sck level lasts 4 clocks
module cfg_host (
    // clock
    input  wire logic clock,
    // serial pins and core pulse
    output logic      cnv,
    output logic      sck,
    output logic      sdi,
    output logic      eoc
);
    timeunit 1ns;
    timeprecision 1ns;

    // pins idle with the converter deselected
    initial begin
        cnv = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
        eoc = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clock);
    endtask : wait_clk

    // one frame, msb first; eoc_at puts an end-of-conversion before that bit
    task automatic frame(input logic [20:0] bits, input int n, input int eoc_at);
        cnv = 1'b0;
        wait_clk(4);
        for (int i = n - 1; i >= 0; i--) begin
            if (n - 1 - i == eoc_at) begin
                eoc = 1'b1;
                wait_clk(1);
                eoc = 1'b0;
            end
            sdi = bits[i];
            wait_clk(4);
            sck = 1'b1;
            wait_clk(4);
            sck = 1'b0;
        end
        // released line must not keep showing the last bit
        sdi = ~sdi;
        wait_clk(4);
        cnv = 1'b1;
        wait_clk(8);
    endtask : frame

    // bare conversion start, no data shifted
    task automatic start();
        cnv = 1'b0;
        wait_clk(4);
        cnv = 1'b1;
        wait_clk(8);
    endtask : start
endmodule : cfg_host

// ---- adc_config_word_lower_fields_bench.sv ----
// self-checking bench of the configuration word block with a host model
// assumes cfg_host.sv and the design files are compiled before it
module adc_config_word_lower_fields_bench;
    import adc_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic        clock, arst_n, cnv, sck, sdi, eoc;
    logic [13:0] cfg_word, last;
    logic [2:0]  input_channel_index, rate_divider, conv_channel;
    logic [7:0]  channel_select;
    logic [1:0]  channel_scan_mode;
    logic        filter_bandwidth_select, quarter_bandwidth, int_ref_en, ref_drive_out;
    logic        ref_buf_en, ext_ref_sel, temp_sensor_en, config_readback_disable;
    logic        readback_append, scan_active, conv_temp_slot, word_refused;
    int          err_total = 0, checks_done = 0, refused_seen = 0, cycles = 0;

    adc_config_word_lower_fields u_adc_config_word_lower_fields (.*);
    cfg_host u_cfg_host (.clock(clock), .cnv(cnv), .sck(sck), .sdi(sdi), .eoc(eoc));

    // clock at 25 MHz
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // refusal pulses last one clock, so count them as they pass; hang guard
    always @(posedge clock) begin
        cycles++;
        if (word_refused === 1'b1) refused_seen++;
        if (cycles == 60000) begin
            err_total++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // {int ref, ref out, buffer, external, sensor} per reference code
    function automatic logic [4:0] exp_ref(input logic [2:0] c);
        case (c)
            3'h1: exp_ref = 5'h1d;
            3'h2: exp_ref = 5'h03;
            3'h3: exp_ref = 5'h07;
            3'h6: exp_ref = 5'h02;
            3'h7: exp_ref = 5'h06;
            default: exp_ref = 5'h00;
        endcase
    endfunction : exp_ref

    task automatic chk_word(input logic [13:0] w);
        chk(16'(cfg_word), 16'(w));
        chk(16'(input_channel_index), 16'(w[9:7]));
        chk(16'(channel_select), 16'(8'h01 << w[9:7]));
        chk(16'({filter_bandwidth_select, quarter_bandwidth}), 16'({w[6], !w[6]}));
        chk(16'(rate_divider), w[6] ? 16'h0001 : 16'h0004);
        chk(16'({int_ref_en, ref_drive_out, ref_buf_en, ext_ref_sel, temp_sensor_en}),
            16'(exp_ref(w[5:3])));
        chk(16'({config_readback_disable, readback_append}), {14'h0, w[0], !w[0]});
        chk(16'({channel_scan_mode, scan_active}), 16'({w[2:1], w[2]}));
    endtask : chk_word

    task automatic put(input logic [13:0] w);
        u_cfg_host.frame({7'h00, w}, 14, -1);
    endtask : put

    // write a scan word (its frame ends in the first start), then three more starts: channels in ch, temperature in tp
    task automatic seq(input logic [13:0] w, input logic [11:0] ch, input logic [3:0] tp);
        put(w);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) u_cfg_host.start();
            chk(16'(conv_channel), 16'(ch[3*k +: 3]));
            chk(16'(conv_temp_slot), 16'(tp[k]));
        end
    endtask : seq

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        static logic [2:0] refs [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
        static logic [1:0] scans [3] = '{2'h0, 2'h2, 2'h3};
        static logic [2:0] rsv [3] = '{3'h0, 3'h4, 3'h5};
        logic [13:0] w;
        int n;
        arst_n = 1'b0;
        void'($urandom(32'h8966850b));
        repeat (6) @(posedge clock);
        @(negedge clock) arst_n = 1'b1;
        repeat (3) @(negedge clock);
        chk_word(14'h3ff9);
        last = 14'h3ff9;
        // random legal words, every usable reference code reached
        for (int i = 0; i < 15; i++) begin
            w = {1'b1, 6'($urandom), 1'($urandom), refs[i % 5], scans[$urandom % 3], 1'($urandom)};
            put(w);
            chk_word(w);
            last = w;
        end
        put({1'b0, 13'($urandom)});
        chk_word(last);
        foreach (rsv[j]) begin
            n = refused_seen;
            put({1'b1, 6'($urandom), 1'b0, rsv[j], 2'h0, 1'b1});
            chk(16'(cfg_word), 16'(last));
            chk(16'(refused_seen), 16'(n + 1));
        end
        u_cfg_host.frame(21'(14'h2bc7 >> 4), 10, -1);
        chk(16'(cfg_word), 16'(last));
        u_cfg_host.frame({7'h55, 14'h2bcf}, 21, 7);
        chk_word(14'h2bcf);
        // scanning order with and without the temperature slot
        seq({4'h8, 3'h1, 1'b1, 3'h7, 2'h3, 1'b1}, {3'h1, 3'h0, 3'h1, 3'h0}, 4'h0);
        seq({4'h8, 3'h1, 1'b1, 3'h7, 2'h2, 1'b1}, {3'h0, 3'h0, 3'h1, 3'h0}, 4'h4);
        put({4'h8, 3'h2, 1'b1, 3'h7, 2'h1, 1'b1});
        chk(16'(channel_scan_mode), 16'h0002);
        chk(16'(input_channel_index), 16'h0002);
        seq({4'h8, 3'h5, 1'b0, 3'h7, 2'h0, 1'b1}, {4{3'h5}}, 4'h0);
        wrap_up();
    end
endmodule : adc_config_word_lower_fields_bench
